// ---- core/pmx_pkg.sv ----
// Package for the monitor exception and instruction sampling block
`default_nettype none
package pmx_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int EAW = 64;
   localparam int ROWS = 8;
   localparam int TOW = 16;
   localparam logic [AW-1:0] OFF_CTL0 = 8'h00;
   localparam logic [AW-1:0] OFF_AUX = 8'h04;
   localparam logic [AW-1:0] OFF_TMO = 8'h08;
   localparam logic [AW-1:0] OFF_STAT = 8'h0c;
   localparam logic [AW-1:0] OFF_SIA_LO = 8'h10;
   localparam logic [AW-1:0] OFF_SIA_HI = 8'h14;
   localparam logic [AW-1:0] OFF_SDA_LO = 8'h18;
   localparam logic [AW-1:0] OFF_SDA_HI = 8'h1c;
   localparam logic [AW-1:0] OFF_SR0_LO = 8'h20;
   localparam logic [AW-1:0] OFF_SR0_HI = 8'h24;
   localparam logic [AW-1:0] OFF_SR1_LO = 8'h28;
   localparam logic [AW-1:0] OFF_MA_VAL = 8'h2c;
   localparam logic [AW-1:0] OFF_MA_MSK = 8'h30;
   localparam logic [AW-1:0] OFF_MA_CTL = 8'h34;
   // Control zero field positions
   localparam int C0_TB_EN = 0;
   localparam int C0_C1_EN = 1;
   localparam int C0_CJ_EN = 2;
   localparam int C0_MONITOR_EXCEPTION_ENABLE = 3;
   // Aux field positions
   localparam int AX_SEL = 0;
   localparam int AX_MARK = 1;
   localparam int AX_MATCH = 4;
   localparam int AX_MASK = 8;
   // Save/restore one bit 33, counted from the msb of 64
   localparam int SR1_SAME = 30;
   // Predecode bit positions: branch, first, split, last
   localparam int PD_B = 3;
   localparam int PD_F = 2;
   localparam int PD_S = 1;
   localparam int PD_L = 0;
   localparam logic [DW-1:0] CTL0_RST = 32'h0000_0000;
   localparam logic [DW-1:0] AUX_RST = 32'h0000_0000;
   localparam logic [TOW-1:0] TMO_RST = 16'h0100;
   typedef enum logic [1:0] {
      PMX_ALL, PMX_UCODE, PMX_ONE_PER, PMX_FIRST_LSU
   } pmx_filt_e;
   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [3:0] pdc;
   } pmx_fetch_s;
   typedef struct packed {
      logic valid;
      logic [3:0] pdc;
      logic tag;
      logic ucode;
      logic first_iop;
      logic first_lsu;
      logic [EAW-1:0] ea;
   } pmx_dec_s;
endpackage : pmx_pkg
`default_nettype wire

// ---- core/pmx_core.sv ----
// Monitor exception generation, address sampling and instruction marking
//
// The plain strobed port and the register offsets were chosen for this implementation.
`default_nettype none
// What this block does
// [RULE_01] Exception needs trigger, its enable, global enable and external irq enable
// [RULE_02] Trigger enables gate one source; global enable gates all sources
// [RULE_03] Taking the exception clears the global enable, freezing sampled addresses
// [RULE_04] Sampled address registers change only while global enable is one
// [RULE_05] Repeated occurrences keep only the latest sample data
// [RULE_06] Pending exception is taken as soon as irq enable rises, unless higher one
// [RULE_07] Taking the exception clears its pending condition
// [RULE_08] Monitor exception beats every other external interrupt
// [RULE_09] Save/restore zero gets the full next-instruction address
// [RULE_10] Save/restore one bit 33 set when data and instruction samples match
// [RULE_11] Instruction sample holds address of the marked instruction
// [RULE_12] Data sample holds an operand address, not necessarily of marked instruction
// [RULE_13] Fetch-side array hit sets or clears the cached sample tag
// [RULE_14] Decode-side: predecode AND mask equal match passes stage one
// [RULE_15] Selector zero picks decode-side, one picks fetch-side marking
// [RULE_16] Stage two filter codes: all, microcode, one per instruction, first load/store
// [RULE_17] Marking only with sample permit, one marked instruction at a time
// [RULE_18] New mark after completion or programmable timeout
// [RULE_19] Every fetch is compared with all rows; isolated-row hits set predecode bits, marked-row hits set the tag
// [RULE_20] Group-isolate hit sets first and last predecode bits
// [RULE_21] Isolate bits scan-only; software row writes to isolated rows are ignored
// [RULE_22] Tags stay in cache; software flushes after changing matches
// [RULE_23] Pending flag is sticky, set on qualified trigger, cleared on take
module pmx_core
   import pmx_pkg::*;
#(
   parameter int ROW_N = ROWS
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [DW-1:0] rdata_out,
   input wire logic tb_bit_in,
   input wire logic ctr1_neg_in,
   input wire logic ctrj_neg_in,
   input wire logic msr_ee_in,
   input wire logic higher_exc_in,
   input wire logic ext_irq_in,
   input wire logic [EAW-1:0] next_ea_in,
   input wire pmx_fetch_s fetch_in,
   input wire pmx_dec_s dec_in,
   input wire logic mark_done_in,
   input wire logic lsu_valid_in,
   input wire logic lsu_marked_in,
   input wire logic [EAW-1:0] lsu_ea_in,
   input wire logic scan_we_in,
   input wire logic [ROW_N-1:0] scan_isolate_in,
   output logic take_out,
   output logic ext_grant_out,
   output logic [EAW-1:0] save_restore_zero_out,
   output logic save_restore_one_same_out,
   output logic [3:0] fetch_pdc_out,
   output logic fetch_tag_out,
   output logic mark_out
);
   localparam int RIW = $clog2(ROW_N);

   logic [DW-1:0] ctl0_q;
   logic [DW-1:0] aux_q;
   logic [TOW-1:0] tmo_q;
   logic pend_q;
   logic tb_q;
   logic [EAW-1:0] sia_q;
   logic [EAW-1:0] sda_q;
   logic same_q;
   logic [EAW-1:0] sr0_q;
   logic sr1_q;
   logic [31:0] ma_val_q;
   logic [31:0] ma_msk_q;
   logic [31:0] row_val_q [ROW_N];
   logic [31:0] row_msk_q [ROW_N];
   logic [ROW_N-1:0] row_mark_q;
   logic [ROW_N-1:0] row_iso_q;
   logic busy_q;
   logic [TOW-1:0] tcnt_q;
   logic [DW-1:0] rdata_q;
   logic take_q;
   logic grant_q;
   logic [3:0] fpdc_q;
   logic ftag_q;
   logic mark_q;

   // Bus decode
   wire logic wr_ctl0 = wr_in && addr_in == OFF_CTL0;
   wire logic wr_aux = wr_in && addr_in == OFF_AUX;
   wire logic wr_tmo = wr_in && addr_in == OFF_TMO;
   wire logic wr_val = wr_in && addr_in == OFF_MA_VAL;
   wire logic wr_msk = wr_in && addr_in == OFF_MA_MSK;
   wire logic wr_mctl = wr_in && addr_in == OFF_MA_CTL;
   wire logic [RIW-1:0] wr_row = wdata_in[RIW-1:0];
   wire logic wr_mark = wdata_in[8];
   wire logic row_open = !row_iso_q[wr_row];
   wire logic commit_row = wr_mctl && row_open; // [RULE_21]

   // Trigger qualification
   wire logic tb_rise = tb_bit_in && !tb_q;
   wire logic monitor_exception_enable = ctl0_q[C0_MONITOR_EXCEPTION_ENABLE];
   wire logic trig_en = (tb_rise && ctl0_q[C0_TB_EN])      // [RULE_02]
      || (ctr1_neg_in && ctl0_q[C0_C1_EN])
      || (ctrj_neg_in && ctl0_q[C0_CJ_EN]);
   wire logic qual = trig_en && monitor_exception_enable; // [RULE_01] [RULE_02]
   wire logic take_w = pend_q && monitor_exception_enable && msr_ee_in      // [RULE_01] [RULE_06]
      && !higher_exc_in;
   wire logic grant_w = ext_irq_in && !take_w; // [RULE_08]

   // Fetch-side row compare
   logic [ROW_N-1:0] hit_w;
   genvar gi;
   generate
      for (gi = 0; gi < ROW_N; gi++) begin : g_row
         assign hit_w[gi] = ((fetch_in.instr ^ row_val_q[gi]) // [RULE_19]
            & row_msk_q[gi]) == 32'h0000_0000;
      end
   endgenerate
   wire logic tag_w = |(hit_w & row_mark_q); // [RULE_13]
   wire logic iso_w = |(hit_w & row_iso_q); // [RULE_20]
   logic [3:0] pdc_w;
   always_comb begin
      pdc_w = fetch_in.pdc;
      if (iso_w) begin
         pdc_w[PD_F] = 1'b1; // [RULE_20]
         pdc_w[PD_L] = 1'b1;
      end
   end

   // Marking stages
   wire logic [3:0] imatch = aux_q[AX_MATCH +: 4];
   wire logic [3:0] imask = aux_q[AX_MASK +: 4];
   wire pmx_filt_e filt = pmx_filt_e'(aux_q[AX_MARK +: 2]);
   wire logic dec_hit = (dec_in.pdc & imask) == imatch; // [RULE_14]
   wire logic st1 = aux_q[AX_SEL] ? dec_in.tag : dec_hit; // [RULE_15]
   logic st2;
   always_comb begin
      unique case (filt) // [RULE_16]
         PMX_ALL: st2 = 1'b1;
         PMX_UCODE: st2 = dec_in.ucode;
         PMX_ONE_PER: st2 = dec_in.first_iop;
         PMX_FIRST_LSU: st2 = dec_in.first_lsu;
      endcase
   end
   wire logic permit = !busy_q; // [RULE_17]
   wire logic mark_w = dec_in.valid && st1 && st2 && permit;
   wire logic tmo_hit = busy_q && tcnt_q >= tmo_q; // [RULE_18]

   // Packed read words
   wire logic [DW-1:0] stat_w = {29'h0, same_q, busy_q, pend_q};
   wire logic [DW-1:0] sr1_w = DW'(sr1_q) << SR1_SAME; // [RULE_10]
   wire logic [DW-1:0] mctl_w = {16'h0, row_iso_q, row_mark_q};

   // Read mux
   logic [DW-1:0] rd_w;
   always_comb begin
      unique case (addr_in)
         OFF_CTL0: rd_w = ctl0_q;
         OFF_AUX: rd_w = aux_q;
         OFF_TMO: rd_w = {16'h0000, tmo_q};
         OFF_STAT: rd_w = stat_w;
         OFF_SIA_LO: rd_w = sia_q[31:0];
         OFF_SIA_HI: rd_w = sia_q[63:32];
         OFF_SDA_LO: rd_w = sda_q[31:0];
         OFF_SDA_HI: rd_w = sda_q[63:32];
         OFF_SR0_LO: rd_w = sr0_q[31:0];
         OFF_SR0_HI: rd_w = sr0_q[63:32];
         OFF_SR1_LO: rd_w = sr1_w;
         OFF_MA_VAL: rd_w = ma_val_q;
         OFF_MA_MSK: rd_w = ma_msk_q;
         OFF_MA_CTL: rd_w = mctl_w;
         default: rd_w = 32'h0000_0000;
      endcase
   end

   // Time-base edge detector
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         tb_q <= 1'b0;
      end else begin
         tb_q <= tb_bit_in;
      end
   end

   // Control registers
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ctl0_q <= CTL0_RST;
         aux_q <= AUX_RST;
         tmo_q <= TMO_RST;
      end else begin
         if (wr_aux) begin
            aux_q <= wdata_in;
         end
         if (wr_tmo) begin
            tmo_q <= wdata_in[TOW-1:0];
         end
         if (take_w) begin
            ctl0_q[C0_MONITOR_EXCEPTION_ENABLE] <= 1'b0; // [RULE_03]
         end else if (wr_ctl0) begin
            ctl0_q <= wdata_in;
         end
      end
   end

   // Pending flag: set wins over the take
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         pend_q <= 1'b0;
      end else if (qual) begin
         pend_q <= 1'b1; // [RULE_23] [RULE_05]
      end else if (take_w) begin
         pend_q <= 1'b0; // [RULE_07] [RULE_23]
      end
   end

   // Sampled addresses, frozen while disabled
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         sia_q <= '0;
         sda_q <= '0;
         same_q <= 1'b0;
      end else if (monitor_exception_enable) begin // [RULE_04]
         if (mark_w) begin
            sia_q <= dec_in.ea; // [RULE_11] [RULE_05]
            same_q <= 1'b0; // [RULE_10]
         end
         if (lsu_valid_in) begin
            sda_q <= lsu_ea_in; // [RULE_12]
            same_q <= lsu_marked_in;
         end
      end
   end

   // Save/restore capture on take
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         sr0_q <= '0;
         sr1_q <= 1'b0;
      end else if (take_w) begin
         sr0_q <= next_ea_in; // [RULE_09]
         sr1_q <= same_q; // [RULE_10]
      end
   end

   // Match array staging and rows
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ma_val_q <= '0;
         ma_msk_q <= '0;
         row_mark_q <= '0;
         row_iso_q <= '0;
      end else begin
         if (wr_val) begin
            ma_val_q <= wdata_in;
         end
         if (wr_msk) begin
            ma_msk_q <= wdata_in;
         end
         if (scan_we_in) begin
            row_iso_q <= scan_isolate_in; // [RULE_21]
         end
         if (commit_row) begin
            row_mark_q[wr_row] <= wr_mark; // [RULE_21]
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         for (int i = 0; i < ROW_N; i++) begin
            row_val_q[i] <= '0;
            row_msk_q[i] <= '1;
         end
      end else if (commit_row) begin
         row_val_q[wr_row] <= ma_val_q;
         row_msk_q[wr_row] <= ma_msk_q;
      end
   end

   // One marked instruction in flight
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         busy_q <= 1'b0;
         tcnt_q <= '0;
      end else if (mark_w) begin
         busy_q <= 1'b1; // [RULE_17]
         tcnt_q <= '0;
      end else if (mark_done_in || tmo_hit) begin
         busy_q <= 1'b0; // [RULE_18]
         tcnt_q <= '0;
      end else if (busy_q) begin
         tcnt_q <= tcnt_q + 16'h0001;
      end
   end

   // Read data stands for one cycle after the strobe
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rd_in ? rd_w : 32'h0000_0000;
      end
   end

   // Exception pulse and registered grant level
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         take_q <= 1'b0;
         grant_q <= 1'b0;
      end else begin
         take_q <= take_w;
         grant_q <= grant_w; // [RULE_08]
      end
   end

   // Fetch predecode outputs
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         fpdc_q <= '0;
         ftag_q <= 1'b0;
      end else begin
         fpdc_q <= fetch_in.valid ? pdc_w : 4'h0;
         ftag_q <= fetch_in.valid && tag_w; // [RULE_13]
      end
   end

   // Mark pulse
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         mark_q <= 1'b0;
      end else begin
         mark_q <= mark_w; // [RULE_17]
      end
   end

   assign rdata_out = rdata_q;
   assign take_out = take_q;
   assign ext_grant_out = grant_q;
   assign save_restore_zero_out = sr0_q;
   assign save_restore_one_same_out = sr1_q;
   assign fetch_pdc_out = fpdc_q;
   assign fetch_tag_out = ftag_q;
   assign mark_out = mark_q;
endmodule : pmx_core
`default_nettype wire

// ---- bench/pmx_monitor.sv ----
// Assertion checker bound to the monitor exception block
`default_nettype none
module pmx_chk import pmx_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic msr_ee_in,
   input wire logic higher_exc_in,
   input wire logic [EAW-1:0] next_ea_in,
   input wire pmx_fetch_s fetch_in,
   input wire pmx_dec_s dec_in,
   input wire logic take_out,
   input wire logic ext_grant_out,
   input wire logic [EAW-1:0] save_restore_zero_out,
   input wire logic [3:0] fetch_pdc_out,
   input wire logic fetch_tag_out,
   input wire logic mark_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);
   sequence s_take;
      take_out ##1 1'b1;
   endsequence
   a_take_cause: assert property (take_out |-> $past(msr_ee_in) && !$past(higher_exc_in))
      else $error("take without irq enable");
   a_no_retake: assert property (s_take |-> !take_out)
      else $error("second take in a row");
   a_save_restore_zero_load: assert property (take_out |-> save_restore_zero_out == $past(next_ea_in))
      else $error("save_restore_zero not next address");
   a_save_restore_zero_hold: assert property (!take_out |-> $stable(save_restore_zero_out))
      else $error("save_restore_zero changed without take");
   a_grant_yield: assert property (take_out |-> !ext_grant_out)
      else $error("grant beside take");
   a_mark_gap: assert property (mark_out |=> !mark_out)
      else $error("two marks back to back");
   a_mark_cause: assert property (mark_out |-> $past(dec_in.valid))
      else $error("mark without decode op");
   a_fetch_idle: assert property (!fetch_in.valid |=> fetch_pdc_out == 4'h0 && !fetch_tag_out)
      else $error("fetch outputs without fetch");
endmodule : pmx_chk
bind pmx_core pmx_chk u_chk (.clk_sys_in, .reset_in, .msr_ee_in, .higher_exc_in, .next_ea_in, .fetch_in,
   .dec_in, .take_out, .ext_grant_out, .save_restore_zero_out, .fetch_pdc_out, .fetch_tag_out, .mark_out);
`default_nettype wire

// ---- bench/pmx_pipe_model.sv ----
// Pipeline model: next address stream and completion of marked ops
`default_nettype none
module pmx_pipe import pmx_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic mark_in,
   input wire logic slow_in,
   output logic [EAW-1:0] next_ea_out,
   output logic done_out
);
   logic [5:0] cnt_q;
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         next_ea_out <= 64'h0000_0000_0000_1000;
         cnt_q <= 6'h00;
         done_out <= 1'b0;
      end else begin
         next_ea_out <= next_ea_out + 64'h4;
         done_out <= (cnt_q == 6'h01);
         if (mark_in)
            cnt_q <= slow_in ? 6'h3f : 6'h03;
         else if (cnt_q != 6'h00)
            cnt_q <= cnt_q - 6'h01;
      end
   end
endmodule : pmx_pipe
`default_nettype wire

// ---- bench/pmx_core_tb_top.sv ----
// Self-checking bench for the monitor exception block
`default_nettype none
module pmx_core_tb_top import pmx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic [AW-1:0] addr = '0;
   logic [DW-1:0] wdata = '0;
   logic [DW-1:0] rdata;
   logic wr = 1'b0, rd = 1'b0, ctr1 = 1'b0, tbb = 1'b0, ee = 1'b0, hexc = 1'b0, eirq = 1'b0, slow = 1'b0, swe = 1'b0;
   logic ctrj = 1'b0, lsu_v = 1'b0, lsu_m = 1'b0;
   logic [EAW-1:0] lsu_ea = '0;
   pmx_fetch_s fe = '0;
   pmx_dec_s de = '0;
   logic [EAW-1:0] ea, save_restore_zero, ea_prev;
   logic take, grant, same, ftag, mark, done;
   logic [3:0] fpdc;
   int num_errors = 0;
   int num_checks = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) ea_prev <= ea;
   pmx_pipe u_pipe (.clk_sys_in, .reset_in, .mark_in(mark), .slow_in(slow), .next_ea_out(ea), .done_out(done));
   pmx_core DUT (.clk_sys_in, .reset_in, .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .tb_bit_in(tbb), .ctr1_neg_in(ctr1), .ctrj_neg_in(ctrj), .msr_ee_in(ee),
      .higher_exc_in(hexc), .ext_irq_in(eirq), .next_ea_in(ea), .fetch_in(fe), .dec_in(de), .mark_done_in(done),
      .lsu_valid_in(lsu_v), .lsu_marked_in(lsu_m), .lsu_ea_in(lsu_ea), .scan_we_in(swe), .scan_isolate_in(8'h01),
      .take_out(take), .ext_grant_out(grant), .save_restore_zero_out(save_restore_zero), .save_restore_one_same_out(same), .fetch_pdc_out(fpdc),
      .fetch_tag_out(ftag), .mark_out(mark));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : cyc
   task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clk_sys_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 chk("register", {32'h0, rdata}, {32'h0, e});
   endtask : rchk
   task automatic dec(input logic [3:0] p, input logic tg, input logic uc, input logic [63:0] e, input logic x);
      @(posedge clk_sys_in);
      de <= '{1'b1, p, tg, uc, !uc, uc, e};
      @(posedge clk_sys_in);
      de.valid <= 1'b0;
      #1 chk("mark", {63'h0, mark}, {63'h0, x});
   endtask : dec
   task automatic fetch(input logic [31:0] ins, input logic et, input logic [3:0] ep);
      @(posedge clk_sys_in);
      fe <= '{1'b1, ins, 4'h0};
      @(posedge clk_sys_in);
      fe.valid <= 1'b0;
      #1 chk("tag", {63'h0, ftag}, {63'h0, et});
      chk("pdc", {60'h0, fpdc}, {60'h0, ep});
   endtask : fetch
   task automatic load_store_unit(input logic [63:0] e, input logic m);
      @(posedge clk_sys_in);
      lsu_v <= 1'b1;
      lsu_m <= m;
      lsu_ea <= e;
      @(posedge clk_sys_in);
      lsu_v <= 1'b0;
   endtask : load_store_unit
   task automatic t_reset();
      rchk(OFF_CTL0, CTL0_RST);
      rchk(OFF_TMO, {16'h0, TMO_RST});
      rchk(8'hfc, 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_gate();
      wreg(OFF_CTL0, 32'h3);
      @(posedge clk_sys_in);
      ctr1 <= 1'b1;
      tbb <= 1'b1;
      ee <= 1'b1;
      rchk(OFF_STAT, 32'h0);
      wreg(OFF_CTL0, 32'h8);
      rchk(OFF_STAT, 32'h0);
      @(posedge clk_sys_in);
      ctr1 <= 1'b0;
      tbb <= 1'b0;
      $display("t_gate done");
   endtask : t_gate
   task automatic t_mark();
      wreg(OFF_TMO, 32'h4);
      wreg(OFF_AUX, 32'h640);
      dec(4'h5, 1'b0, 1'b0, 64'h100, 1'b1);
      dec(4'h5, 1'b0, 1'b0, 64'h200, 1'b0);
      cyc(4);
      dec(4'h2, 1'b0, 1'b0, 64'h300, 1'b0);
      dec(4'h4, 1'b0, 1'b0, 64'h400, 1'b1);
      rchk(OFF_SIA_LO, 32'h400);
      cyc(6);
      wreg(OFF_AUX, 32'h642);
      slow <= 1'b1;
      dec(4'h4, 1'b0, 1'b0, 64'h500, 1'b0);
      dec(4'h4, 1'b0, 1'b1, 64'h600, 1'b1);
      cyc(8);
      dec(4'h4, 1'b0, 1'b1, 64'h700, 1'b1);
      slow <= 1'b0;
      cyc(8);
      wreg(OFF_AUX, 32'h644);
      dec(4'h4, 1'b0, 1'b1, 64'h710, 1'b0);
      dec(4'h4, 1'b0, 1'b0, 64'h720, 1'b1);
      cyc(8);
      wreg(OFF_AUX, 32'h646);
      dec(4'h4, 1'b0, 1'b0, 64'h730, 1'b0);
      dec(4'h4, 1'b0, 1'b1, 64'h740, 1'b1);
      cyc(8);
      wreg(OFF_AUX, 32'h1);
      dec(4'h4, 1'b0, 1'b1, 64'h800, 1'b0);
      dec(4'h0, 1'b1, 1'b1, 64'h900, 1'b1);
      $display("t_mark done");
   endtask : t_mark
   task automatic t_take();
      int i;
      wreg(OFF_CTL0, 32'ha);
      @(posedge clk_sys_in);
      ee <= 1'b0;
      hexc <= 1'b1;
      eirq <= 1'b1;
      ctr1 <= 1'b1;
      @(posedge clk_sys_in);
      ctr1 <= 1'b0;
      rchk(OFF_STAT, 32'h1);
      ee <= 1'b1;
      rchk(OFF_STAT, 32'h1);
      hexc <= 1'b0;
      for (i = 0; i < 20 && take !== 1'b1; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
      chk("take", {63'h0, take}, 64'h1);
      if (take !== 1'b1)
         give_verdict();
      chk("save_restore_zero", save_restore_zero, ea_prev);
      chk("grant", {63'h0, grant}, 64'h0);
      rchk(OFF_CTL0, 32'h2);
      rchk(OFF_STAT, 32'h0);
      dec(4'h0, 1'b1, 1'b1, 64'ha00, 1'b1);
      rchk(OFF_SIA_LO, 32'h900);
      $display("t_take done");
   endtask : t_take
   task automatic t_sample();
      int i;
      wreg(OFF_CTL0, 32'hc);
      load_store_unit(64'hb00, 1'b0);
      load_store_unit(64'hc00, 1'b1);
      rchk(OFF_SDA_LO, 32'hc00);
      rchk(OFF_STAT, 32'h4);
      @(posedge clk_sys_in);
      ctrj <= 1'b1;
      @(posedge clk_sys_in);
      ctrj <= 1'b0;
      for (i = 0; i < 20 && take !== 1'b1; i++) begin
         @(posedge clk_sys_in);
         #1;
      end
      chk("take", {63'h0, take}, 64'h1);
      if (take !== 1'b1)
         give_verdict();
      chk("save_restore_one", {63'h0, same}, 64'h1);
      load_store_unit(64'hd00, 1'b0);
      rchk(OFF_SDA_LO, 32'hc00);
      $display("t_sample done");
   endtask : t_sample
   task automatic t_fetch();
      wreg(OFF_MA_VAL, 32'h7c00_0214);
      wreg(OFF_MA_MSK, 32'hffff_ffff);
      wreg(OFF_MA_CTL, 32'h100);
      fetch(32'h7c00_0214, 1'b1, 4'h0);
      fetch(32'h7c00_0215, 1'b0, 4'h0);
      wreg(OFF_MA_CTL, 32'h0);
      fetch(32'h7c00_0214, 1'b0, 4'h0);
      wreg(OFF_MA_CTL, 32'h100);
      @(posedge clk_sys_in);
      swe <= 1'b1;
      @(posedge clk_sys_in);
      swe <= 1'b0;
      fetch(32'h7c00_0214, 1'b1, 4'h5);
      wreg(OFF_MA_CTL, 32'h0);
      rchk(OFF_MA_CTL, 32'h101);
      $display("t_fetch done");
   endtask : t_fetch
   initial begin
      cyc(6);
      reset_in <= 1'b0;
      t_reset();
      t_gate();
      t_mark();
      t_take();
      t_sample();
      t_fetch();
      give_verdict();
   end
endmodule : pmx_core_tb_top
`default_nettype wire
